// >>> common/eei_pkg.sv
package eei_pkg;

    // Bus geometry.
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned SEL_W       = 4;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned ADR_W       = 18;
    localparam int unsigned ADR_IDX_LSB = 2;
    localparam int unsigned IDX_W       = 16;

    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] ENABLE_IDX = 16'he50a;
    localparam logic [IDX_W-1:0] STATUS_IDX = 16'he580;
    localparam logic [IDX_W-1:0] MEASUREMENT_MODE_REG_IDX  = 16'he581;
    localparam logic [IDX_W-1:0] PULSE_OUTPUT_MODE_REG_IDX = 16'he582;

    // Event and enable bit positions, shared by status and enable.
    localparam int unsigned EV_W          = 19;
    localparam int unsigned EN_TOT_ACT    = 0;
    localparam int unsigned EN_FUND_ACT   = 1;
    localparam int unsigned EN_TOT_REACT  = 2;
    localparam int unsigned EN_FUND_REACT = 3;
    localparam int unsigned EN_APPARENT   = 4;
    localparam int unsigned EN_LINE_END   = 5;
    localparam int unsigned EN_ACT_A      = 6;
    localparam int unsigned EN_PSUM1      = 9;
    localparam int unsigned EN_REACT_A    = 10;
    localparam int unsigned EN_PSUM2      = 13;
    localparam int unsigned EN_PULSE1     = 14;
    localparam int unsigned EN_DSP_DONE   = 17;
    localparam int unsigned EN_PSUM3      = 18;

    // Layout of the change detector input vector.
    localparam int unsigned PHASES        = 3;
    localparam int unsigned DET_W         = 27;
    localparam int unsigned DET_TOT_ACT   = 0;
    localparam int unsigned DET_FUND_ACT  = 3;
    localparam int unsigned DET_TOT_REACT = 6;
    localparam int unsigned DET_FUND_REAC = 9;
    localparam int unsigned DET_APPARENT  = 12;
    localparam int unsigned DET_ACT_SIGN  = 15;
    localparam int unsigned DET_REA_SIGN  = 18;
    localparam int unsigned DET_PSUM      = 21;
    localparam int unsigned DET_PULSE     = 24;

    // Measurement mode and pulse output mode fields.
    localparam int unsigned MM_W         = 2;
    localparam int unsigned MM_ACT_SEL   = 0;
    localparam int unsigned MM_REACT_SEL = 1;
    localparam int unsigned CF_W         = 12;
    localparam int unsigned CF_SEL_W     = 3;
    localparam int unsigned CF_SEL1_LSB  = 0;
    localparam int unsigned CF_SEL2_LSB  = 3;
    localparam int unsigned CF_SEL3_LSB  = 6;
    localparam int unsigned CF_DIS1      = 9;
    localparam int unsigned CF_DIS2      = 10;
    localparam int unsigned CF_DIS3      = 11;

    // Reset values.
    localparam logic [DATA_W-1:0] ENABLE_RST = 32'h0000_0000;
    localparam logic [EV_W-1:0]   STATUS_RST = 19'h0_0000;
    localparam logic [MM_W-1:0]   MEASUREMENT_MODE_REG_RST  = 2'h0;
    localparam logic [CF_W-1:0]   PULSE_OUTPUT_MODE_REG_RST = 12'h000;
    localparam logic [PHASES-1:0] PULSE_IDLE = 3'h7;
    localparam logic [EV_W-1:0]   EV_MASK    = 19'h7_ffff;

    function automatic logic [DATA_W-1:0] eei_sel_mask(
        input logic [SEL_W-1:0] sel
    );
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < SEL_W; i++) begin
            if (sel[i]) begin
                m[i*BYTE_W +: BYTE_W] = {BYTE_W{1'b1}};
            end
        end
        return m;
    endfunction : eei_sel_mask

    function automatic logic [DATA_W-1:0] eei_merge(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] wdat,
        input logic [SEL_W-1:0]  sel
    );
        logic [DATA_W-1:0] m;
        m = eei_sel_mask(sel);
        return (old & ~m) | (wdat & m);
    endfunction : eei_merge

endpackage : eei_pkg

// >>> hdl/eei_change_det.sv
`timescale 1ns/1ps
module eei_change_det #(
    parameter int unsigned W = 1
) (
    // Clock
    input  wire logic         clk,
    // Sampled levels and their edges
    input  wire logic [W-1:0] sample,
    output logic      [W-1:0] chg,
    output logic      [W-1:0] fall
);
    logic [W-1:0] prev;
    logic [W-1:0] next_prev;

    // The previous value also loads during reset, so no false edge
    // is seen at the release.
    always_comb begin
        next_prev = sample;
        chg       = sample ^ prev;
        fall      = prev & ~sample;
    end

    always_ff @(posedge clk) begin
        prev <= next_prev;
    end

endmodule : eei_change_det

// >>> hdl/eei_wb_slave.sv
`timescale 1ns/1ps
module eei_wb_slave
    import eei_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Wishbone side
    input  wire logic [ADR_W-1:0]       adr_i,
    input  wire logic [DATA_W-1:0]      dat_i,
    input  wire logic [SEL_W-1:0]       sel_i,
    input  wire logic                   we_i,
    input  wire logic                   stb_i,
    input  wire logic                   cyc_i,
    output logic      [DATA_W-1:0]      dat_o,
    output logic                        ack_o,
    // Register file side
    output logic                        wr_stb,
    output logic      [IDX_W-1:0]       idx,
    output logic      [DATA_W-1:0]      wr_data,
    output logic      [SEL_W-1:0]       wr_sel,
    input  wire logic [DATA_W-1:0]      rd_data
);
    logic              req;
    logic              next_ack;
    logic [DATA_W-1:0] next_dat;

    always_comb begin
        idx      = adr_i[ADR_W-1:ADR_IDX_LSB];
        req      = cyc_i & stb_i;
        next_ack = req & ~ack_o;
        next_dat = next_ack ? rd_data : dat_o;
        // Writes land on the edge where the master samples ack.
        wr_stb   = req & we_i & ack_o;
        wr_data  = dat_i;
        wr_sel   = sel_i;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= next_ack;
            dat_o <= next_dat;
        end
    end

endmodule : eei_wb_slave

// >>> hdl/eei_event_mask.sv
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
// Functional notes
// - Enable bit 0: interrupt on bit 30 change of total active energy.
// - Enable bit 1: interrupt on bit 30 change of fundamental active.
// - Enable bit 2: interrupt on bit 30 change of total reactive.
// - Enable bit 3: interrupt on bit 30 change of fundamental reactive.
// - Enable bit 4: interrupt on bit 30 change of apparent energy.
// - Enable bit 5: interrupt at end of line-cycle accumulation.
// - Bits 6-8: active power sign change per phase; mode bit 0 picks.
// - Bits 10-12: reactive power sign change per phase; mode bit 1 picks.
// - Bits 9, 13, 18: pulse datapath 1-3 summed power sign change.
// - Bits 14-16: falling edge of pulse datapath 1-3.
// - Pulse interrupts still fire with pins disabled by bits 9-11.
// - Pulse mode fields [2:0], [5:3], [8:6] pick each output's power.
// - Enable bit 17: interrupt when the 8 kHz DSP cycle completes.
// - Enable bits 31:19 do nothing; all enable bits reset to zero.
module eei_event_mask (
    // Clock and reset
    input  wire logic                          CLK,
    input  wire logic                          RESET,
    // Wishbone slave
    input  wire logic [eei_pkg::ADR_W-1:0]     ADR_I,
    input  wire logic [eei_pkg::DATA_W-1:0]    DAT_I,
    input  wire logic [eei_pkg::SEL_W-1:0]     SEL_I,
    input  wire logic                          WE_I,
    input  wire logic                          STB_I,
    input  wire logic                          CYC_I,
    output logic      [eei_pkg::DATA_W-1:0]    DAT_O,
    output logic                               ACK_O,
    // Energy accumulator bit 30, one bit per phase A, B, C
    input  wire logic [eei_pkg::PHASES-1:0]    TOT_ACT_ENERGY_B30,
    input  wire logic [eei_pkg::PHASES-1:0]    FUND_ACT_ENERGY_B30,
    input  wire logic [eei_pkg::PHASES-1:0]    TOT_REACT_ENERGY_B30,
    input  wire logic [eei_pkg::PHASES-1:0]    FUND_REACT_ENERGY_B30,
    input  wire logic [eei_pkg::PHASES-1:0]    APPARENT_ENERGY_B30,
    // Sequencer pulses
    input  wire logic                          LINE_CYCLE_END,
    input  wire logic                          DSP_CYCLE_DONE,
    // Power signs, one bit per phase, 1 means negative
    input  wire logic [eei_pkg::PHASES-1:0]    ACT_SIGN_TOTAL,
    input  wire logic [eei_pkg::PHASES-1:0]    ACT_SIGN_FUND,
    input  wire logic [eei_pkg::PHASES-1:0]    REACT_SIGN_TOTAL,
    input  wire logic [eei_pkg::PHASES-1:0]    REACT_SIGN_FUND,
    input  wire logic [eei_pkg::PHASES-1:0]    PULSE_SUM_SIGN,
    // Pulse datapaths, active low, before the pin disable
    input  wire logic [eei_pkg::PHASES-1:0]    PULSE_RAW,
    // Pulse output pins and their power selects
    output logic      [eei_pkg::PHASES-1:0]    PULSE_OUTPUT,
    output logic      [eei_pkg::CF_SEL_W-1:0]  PULSE1_POWER_SELECT,
    output logic      [eei_pkg::CF_SEL_W-1:0]  PULSE2_POWER_SELECT,
    output logic      [eei_pkg::CF_SEL_W-1:0]  PULSE3_POWER_SELECT,
    // Interrupt request, level, active high
    output logic                               IRQ
);
    import eei_pkg::*;

    logic                 wr_stb;
    logic [IDX_W-1:0]     idx;
    logic [DATA_W-1:0]    wr_data;
    logic [SEL_W-1:0]     wr_sel;
    logic [DATA_W-1:0]    rd_data;

    logic [DATA_W-1:0]    enable;
    logic [DATA_W-1:0]    next_enable;
    logic [EV_W-1:0]      status;
    logic [EV_W-1:0]      next_status;
    logic [MM_W-1:0]      measurement_mode_reg;
    logic [MM_W-1:0]      next_measurement_mode_reg;
    logic [CF_W-1:0]      pulse_output_mode_reg;
    logic [CF_W-1:0]      next_pulse_output_mode_reg;
    logic [PHASES-1:0]    next_pulse_pin;

    logic [PHASES-1:0]    act_sign;
    logic [PHASES-1:0]    react_sign;
    logic [DET_W-1:0]     det_in;
    logic [DET_W-1:0]     det_chg;
    logic [DET_W-1:0]     det_fall;
    logic [EV_W-1:0]      ev;
    logic [EV_W-1:0]      clr;
    logic [PHASES-1:0]    pin_dis;
    logic [DATA_W-1:0]    lane_mask;
    logic [DATA_W-1:0]    cf_merged;

    eei_wb_slave u_bus (
        .clk     (CLK),
        .reset   (RESET),
        .adr_i   (ADR_I),
        .dat_i   (DAT_I),
        .sel_i   (SEL_I),
        .we_i    (WE_I),
        .stb_i   (STB_I),
        .cyc_i   (CYC_I),
        .dat_o   (DAT_O),
        .ack_o   (ACK_O),
        .wr_stb  (wr_stb),
        .idx     (idx),
        .wr_data (wr_data),
        .wr_sel  (wr_sel),
        .rd_data (rd_data)
    );

    // Sign source selection happens before the edge detector, so a
    // change of mode while the two sources differ raises an event.
    always_comb begin
        act_sign   = measurement_mode_reg[MM_ACT_SEL] ? ACT_SIGN_FUND : ACT_SIGN_TOTAL;
        react_sign = measurement_mode_reg[MM_REACT_SEL] ? REACT_SIGN_FUND
                                         : REACT_SIGN_TOTAL;
        det_in = {PULSE_RAW, PULSE_SUM_SIGN, react_sign, act_sign,
                  APPARENT_ENERGY_B30, FUND_REACT_ENERGY_B30,
                  TOT_REACT_ENERGY_B30, FUND_ACT_ENERGY_B30,
                  TOT_ACT_ENERGY_B30};
    end

    eei_change_det #(
        .W (DET_W)
    ) u_det (
        .clk    (CLK),
        .sample (det_in),
        .chg    (det_chg),
        .fall   (det_fall)
    );

    // Event vector in the status and enable layout.
    always_comb begin
        ev = '0;
        ev[EN_TOT_ACT]    = |det_chg[DET_TOT_ACT +: PHASES];
        ev[EN_FUND_ACT]   = |det_chg[DET_FUND_ACT +: PHASES];
        ev[EN_TOT_REACT]  = |det_chg[DET_TOT_REACT +: PHASES];
        ev[EN_FUND_REACT] = |det_chg[DET_FUND_REAC +: PHASES];
        ev[EN_APPARENT]   = |det_chg[DET_APPARENT +: PHASES];
        ev[EN_LINE_END]   = LINE_CYCLE_END;
        ev[EN_ACT_A +: PHASES]   = det_chg[DET_ACT_SIGN +: PHASES];
        ev[EN_REACT_A +: PHASES] = det_chg[DET_REA_SIGN +: PHASES];
        ev[EN_PSUM1] = det_chg[DET_PSUM];
        ev[EN_PSUM2] = det_chg[DET_PSUM + 1];
        ev[EN_PSUM3] = det_chg[DET_PSUM + 2];
        // Taken from the datapath, ahead of the pin disable.
        ev[EN_PULSE1 +: PHASES] = det_fall[DET_PULSE +: PHASES];
        ev[EN_DSP_DONE] = DSP_CYCLE_DONE;
    end

    // Register writes and status flags.
    always_comb begin
        next_enable = enable;
        next_measurement_mode_reg  = measurement_mode_reg;
        next_pulse_output_mode_reg = pulse_output_mode_reg;
        clr         = '0;
        lane_mask   = eei_sel_mask(wr_sel);
        cf_merged   = eei_merge({{(DATA_W-CF_W){1'b0}}, pulse_output_mode_reg},
                                wr_data, wr_sel);
        if (wr_stb) begin
            unique case (idx)
                ENABLE_IDX: begin
                    next_enable = eei_merge(enable, wr_data, wr_sel)
                                  & {{(DATA_W-EV_W){1'b0}}, EV_MASK};
                end
                STATUS_IDX: begin
                    clr = wr_data[EV_W-1:0] & lane_mask[EV_W-1:0];
                end
                MEASUREMENT_MODE_REG_IDX: begin
                    next_measurement_mode_reg = (wr_data[MM_W-1:0] & lane_mask[MM_W-1:0])
                               | (measurement_mode_reg & ~lane_mask[MM_W-1:0]);
                end
                PULSE_OUTPUT_MODE_REG_IDX: begin
                    next_pulse_output_mode_reg = cf_merged[CF_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // An event in the same cycle as its clear keeps the flag set,
        // and flags set whatever the enable says.
        next_status = (status & ~clr) | ev;
    end

    // Pin disable holds the pin high; the datapath keeps running.
    always_comb begin
        pin_dis        = {pulse_output_mode_reg[CF_DIS3], pulse_output_mode_reg[CF_DIS2], pulse_output_mode_reg[CF_DIS1]};
        next_pulse_pin = PULSE_RAW | pin_dis;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            enable       <= ENABLE_RST;
            status       <= STATUS_RST;
            measurement_mode_reg        <= MEASUREMENT_MODE_REG_RST;
            pulse_output_mode_reg       <= PULSE_OUTPUT_MODE_REG_RST;
            PULSE_OUTPUT <= PULSE_IDLE;
        end else begin
            enable       <= next_enable;
            status       <= next_status;
            measurement_mode_reg        <= next_measurement_mode_reg;
            pulse_output_mode_reg       <= next_pulse_output_mode_reg;
            PULSE_OUTPUT <= next_pulse_pin;
        end
    end

    // Read mux; unmapped indices read as zero.
    always_comb begin
        unique case (idx)
            ENABLE_IDX: rd_data = enable;
            STATUS_IDX: rd_data = {{(DATA_W-EV_W){1'b0}}, status};
            MEASUREMENT_MODE_REG_IDX:  rd_data = {{(DATA_W-MM_W){1'b0}}, measurement_mode_reg};
            PULSE_OUTPUT_MODE_REG_IDX: rd_data = {{(DATA_W-CF_W){1'b0}}, pulse_output_mode_reg};
            default:    rd_data = '0;
        endcase
    end

    always_comb begin
        PULSE1_POWER_SELECT = pulse_output_mode_reg[CF_SEL1_LSB +: CF_SEL_W];
        PULSE2_POWER_SELECT = pulse_output_mode_reg[CF_SEL2_LSB +: CF_SEL_W];
        PULSE3_POWER_SELECT = pulse_output_mode_reg[CF_SEL3_LSB +: CF_SEL_W];
        IRQ = |(status & enable[EV_W-1:0]);
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    a_tot_act_half: assert property (
        $changed(TOT_ACT_ENERGY_B30) |=> status[EN_TOT_ACT])
        else $error("total active half flag missed");
    a_fund_act_half: assert property (
        $changed(FUND_ACT_ENERGY_B30) |=> status[EN_FUND_ACT])
        else $error("fundamental active half flag missed");
    a_tot_react_half: assert property (
        $changed(TOT_REACT_ENERGY_B30) |=> status[EN_TOT_REACT])
        else $error("total reactive half flag missed");
    a_fund_react_half: assert property (
        $changed(FUND_REACT_ENERGY_B30) |=> status[EN_FUND_REACT])
        else $error("fundamental reactive half flag missed");
    a_apparent_half: assert property (
        $changed(APPARENT_ENERGY_B30) |=> status[EN_APPARENT])
        else $error("apparent half flag missed");
    a_line_end_flag: assert property (
        LINE_CYCLE_END |=> status[EN_LINE_END])
        else $error("line cycle end flag missed");
    a_act_sign_total: assert property (
        (!measurement_mode_reg[MM_ACT_SEL] && $stable(measurement_mode_reg) && $changed(ACT_SIGN_TOTAL[0]))
        |=> status[EN_ACT_A])
        else $error("phase A active sign flag missed");
    a_react_sign_fund: assert property (
        (measurement_mode_reg[MM_REACT_SEL] && $stable(measurement_mode_reg)
         && $changed(REACT_SIGN_FUND[2])) |=> status[EN_REACT_A + 2])
        else $error("phase C reactive sign flag missed");
    a_sum_sign_three: assert property (
        $changed(PULSE_SUM_SIGN[2]) |=> status[EN_PSUM3])
        else $error("pulse 3 sum sign flag missed");
    a_pulse_fall_flag: assert property (
        $fell(PULSE_RAW[1]) |=> status[EN_PULSE1 + 1])
        else $error("pulse 2 fall flag missed");
    a_pulse_pin_off: assert property (
        pulse_output_mode_reg[CF_DIS1] |=> PULSE_OUTPUT[0])
        else $error("disabled pulse pin went low");
    a_select_follows: assert property (
        $changed(pulse_output_mode_reg)
        |-> PULSE2_POWER_SELECT == pulse_output_mode_reg[CF_SEL2_LSB +: CF_SEL_W])
        else $error("pulse 2 select mismatch");
    a_dsp_done_flag: assert property (
        DSP_CYCLE_DONE |=> status[EN_DSP_DONE])
        else $error("dsp done flag missed");
    a_upper_enable: assert property (
        (enable >> EV_W) == '0)
        else $error("upper enable bits not zero");
    a_irq_follows: assert property (
        (status[EN_LINE_END] && enable[EN_LINE_END]) |-> IRQ ##1
        (IRQ || !(status[EN_LINE_END] && enable[EN_LINE_END])))
        else $error("interrupt not raised for enabled flag");
    a_irq_quiet: assert property (
        ((status & enable[EV_W-1:0]) == '0) |-> !IRQ)
        else $error("interrupt raised with no enabled flag");
    a_masked_sets: assert property (
        (LINE_CYCLE_END && !enable[EN_LINE_END]) |=> status[EN_LINE_END])
        else $error("masked event did not set its flag");

endmodule : eei_event_mask

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import eei_pkg::*;

    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADR_W-1:0]  adr = '0;
    logic [DATA_W-1:0] dat_i = '0;
    logic [SEL_W-1:0]  sel = '0;
    logic              we = 1'b0;
    logic              stb = 1'b0;
    logic              cyc = 1'b0;
    logic [DATA_W-1:0] dat_o;
    logic              ack;
    logic [2:0]        tot_act = '0, fund_act = '0, tot_react = '0;
    logic [2:0]        fund_react = '0, apparent = '0, psum = '0;
    logic [2:0]        act_tot = '0, act_fund = '0;
    logic [2:0]        react_tot = '0, react_fund = '0;
    logic [2:0]        raw = 3'h7;
    logic              line_end = 1'b0;
    logic              dsp_done = 1'b0;
    logic [2:0]        pulse_out, psel1, psel2, psel3;
    logic              irq;
    int                n_mismatch = 0;
    int                samples_checked = 0;
    logic [DATA_W-1:0] d;

    always #12.5 clk = ~clk;

    eei_event_mask dut (
        .CLK(clk), .RESET(rst), .ADR_I(adr), .DAT_I(dat_i), .SEL_I(sel),
        .WE_I(we), .STB_I(stb), .CYC_I(cyc), .DAT_O(dat_o), .ACK_O(ack),
        .TOT_ACT_ENERGY_B30(tot_act), .FUND_ACT_ENERGY_B30(fund_act),
        .TOT_REACT_ENERGY_B30(tot_react),
        .FUND_REACT_ENERGY_B30(fund_react),
        .APPARENT_ENERGY_B30(apparent), .LINE_CYCLE_END(line_end),
        .DSP_CYCLE_DONE(dsp_done), .ACT_SIGN_TOTAL(act_tot),
        .ACT_SIGN_FUND(act_fund), .REACT_SIGN_TOTAL(react_tot),
        .REACT_SIGN_FUND(react_fund), .PULSE_SUM_SIGN(psum),
        .PULSE_RAW(raw), .PULSE_OUTPUT(pulse_out),
        .PULSE1_POWER_SELECT(psel1), .PULSE2_POWER_SELECT(psel2),
        .PULSE3_POWER_SELECT(psel3), .IRQ(irq)
    );

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Data is taken at the edge where ack is sampled high, and the
    // request drops at that same edge.
    task automatic wb(input logic w, input logic [IDX_W-1:0] ix,
                      input logic [DATA_W-1:0] wd, input logic [SEL_W-1:0] sl,
                      output logic [DATA_W-1:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= {ix, 2'b00};
        dat_i <= wd;
        sel   <= sl;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            n_mismatch++;
            $display("Error %0t: bus answer missing", $time);
            finish_test();
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        // Let the write settle before the caller looks at outputs.
        @(negedge clk);
    endtask : wb

    task automatic wr(input logic [IDX_W-1:0] ix, input logic [31:0] v,
                      input logic [3:0] sl);
        logic [DATA_W-1:0] x;
        wb(1'b1, ix, v, sl, x);
    endtask : wr

    task automatic rdc(input logic [IDX_W-1:0] ix, input logic [31:0] e,
                       input string s);
        logic [DATA_W-1:0] x;
        wb(1'b0, ix, '0, 4'hf, x);
        chk(x, e, s);
    endtask : rdc

    task automatic irqc(input logic e, input string s);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, e}, s);
    endtask : irqc

    // Inverts the source of one event; ids 19 to 21 are the unselected
    // or fundamental sign sources used for the mode checks.
    task automatic flip(input int id);
        logic [2:0] m;
        if (id >= 10 && id <= 12) begin
            m = 3'h1 << (id - 10);
        end else if (id >= 14 && id <= 16) begin
            m = 3'h1 << (id - 14);
        end else begin
            m = 3'h1 << (id % 3);
        end
        @(posedge clk);
        case (id)
            0: tot_act <= tot_act ^ m;
            1: fund_act <= fund_act ^ m;
            2: tot_react <= tot_react ^ m;
            3: fund_react <= fund_react ^ m;
            4: apparent <= apparent ^ m;
            5: line_end <= ~line_end;
            6, 7, 8, 21: act_tot <= act_tot ^ m;
            9: psum <= psum ^ 3'h1;
            10, 11, 12: react_tot <= react_tot ^ m;
            13: psum <= psum ^ 3'h2;
            14, 15, 16: raw <= raw ^ m;
            17: dsp_done <= ~dsp_done;
            18: psum <= psum ^ 3'h4;
            19: act_fund <= act_fund ^ m;
            20: react_fund <= react_fund ^ m;
            default: ;
        endcase
    endtask : flip

    task automatic fire(input int id);
        flip(id);
        repeat (2) @(posedge clk);
        flip(id);
        repeat (3) @(posedge clk);
    endtask : fire

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdc(ENABLE_IDX, 32'h0, "enable reset");
        rdc(STATUS_IDX, 32'h0, "status reset");
        irqc(1'b0, "irq after reset");
        chk({29'h0, pulse_out}, 32'h7, "pulse idle");
        for (int i = 0; i < 19; i++) begin
            fire(i);
            rdc(STATUS_IDX, 32'h1 << i, "status set");
            irqc(1'b0, "irq while disabled");
            wr(ENABLE_IDX, 32'h1 << i, 4'hf);
            irqc(1'b1, "irq when enabled");
            chk({31'h0, irq}, 32'h1, "event irq");
            wr(STATUS_IDX, 32'h1 << i, 4'hf);
            irqc(1'b0, "irq after clear");
            wr(ENABLE_IDX, 32'h0, 4'hf);
        end
        // Mode bits move the sign watch onto the fundamental sources.
        wr(MEASUREMENT_MODE_REG_IDX, 32'h3, 4'hf);
        rdc(MEASUREMENT_MODE_REG_IDX, 32'h3, "mode readback");
        fire(21);
        rdc(STATUS_IDX, 32'h0, "unselected sign");
        fire(19);
        fire(20);
        rdc(STATUS_IDX, 32'h0000_1080, "fund signs");
        wr(STATUS_IDX, 32'hffff_ffff, 4'hf);
        wr(MEASUREMENT_MODE_REG_IDX, 32'h0, 4'hf);
        // Pins 1 and 3 disabled, pin 2 live; selects 7, 2 and 4.
        wr(PULSE_OUTPUT_MODE_REG_IDX, 32'h0000_0b17, 4'hf);
        rdc(PULSE_OUTPUT_MODE_REG_IDX, 32'h0000_0b17, "pulse mode");
        chk({29'h0, psel1, psel2, psel3}, 32'h1d4, "selects");
        wr(ENABLE_IDX, 32'h0001_c000, 4'hf);
        @(posedge clk);
        raw <= 3'h0;
        repeat (3) @(negedge clk);
        chk({29'h0, pulse_out}, 32'h5, "pins disabled");
        rdc(STATUS_IDX, 32'h0001_c000, "pulse status");
        irqc(1'b1, "pulse irq");
        @(posedge clk);
        raw <= 3'h7;
        wr(STATUS_IDX, 32'h0001_c000, 4'hf);
        irqc(1'b0, "pulse cleared");
        wr(ENABLE_IDX, 32'hffff_ffff, 4'hf);
        rdc(ENABLE_IDX, 32'h0007_ffff, "upper bits");
        irqc(1'b0, "no status no irq");
        wr(ENABLE_IDX, 32'h0, 4'hf);
        wr(ENABLE_IDX, 32'hffff_ffff, 4'h2);
        rdc(ENABLE_IDX, 32'h0000_ff00, "byte lane");
        wr(16'h0001, 32'hffff_ffff, 4'hf);
        rdc(16'h0001, 32'h0, "unmapped read");
        rdc(ENABLE_IDX, 32'h0000_ff00, "unmapped write");
        finish_test();
    end
endmodule : tb_top
